// [logic/column_loader_pkg.sv]
// Purpose: Shared constants and types for the six-channel column load sequencer
// Assumes: One 125 MHz system clock; panel pins are synchronous to it
// Notes: Register offsets are byte addresses on a 32-bit AHB-Lite bus

package column_loader_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned CHANNELS = 6;
  localparam int unsigned WORD_W = 10;
  localparam logic [2:0] LAST_CHANNEL = 3'h5;
  localparam logic [2:0] SEQ_ADDRESS = 3'h7;
  // Sequence counter value meaning "no sequence running"
  localparam logic [2:0] SEQ_DONE = 3'h6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] OUT_BASE_OFFSET = 8'h10;
  localparam logic [7:0] OUT_LAST_OFFSET = 8'h24;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // CTRL field positions
  localparam int unsigned CTRL_DIR_BIT = 0;
  localparam int unsigned CTRL_PARITY_BIT = 1;
  localparam int unsigned CTRL_INVERT_BIT = 2;

  // STATUS field positions
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_COUNT_LSB = 1;
  localparam int unsigned STAT_XFER_BIT = 4;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [WORD_W-1:0] word_type;
  typedef logic [CHANNELS-1:0][WORD_W-1:0] bank_type;

  // Pixel port from the panel timing controller
  typedef struct packed {
    logic panel_clock;
    logic sequence_start_or_select;
    logic transfer_strobe;
    logic [2:0] channel_address;
    word_type pixel_word;
  } panel_in_type;

  // Software controls
  typedef struct packed {
    logic direction;
    logic edge_parity;
    logic polarity_invert;
  } ctrl_type;

  // Block state reported to software
  typedef struct packed {
    logic seq_active;
    logic [2:0] seq_count;
    logic xfer_pending;
  } status_type;

endpackage

// [logic/column_latch_bank.sv]
// Purpose: Two-stage latches of the six column channels
// Assumes: Load enables are one-hot or zero
// Notes: Second stage moves as a whole so all outputs change together

`timescale 1ns/1ps

module column_latch_bank
  import column_loader_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // First-stage load
  input wire logic [CHANNELS-1:0] load_en,
  input wire word_type load_word,
  // Transfer
  input wire logic xfer_fire,
  input wire logic invert_in,
  // Latch contents
  output bank_type stage1,
  output bank_type stage2,
  output logic invert_out
);

  bank_type stage1_q;
  bank_type stage2_q;
  logic invert_q;

  // First stage: each channel takes the shared word when enabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= '0;
    end
    else
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        if (load_en[i])
        begin
          stage1_q[i] <= load_word;
        end
      end
    end
  end

  // Second stage and slope flag move together in one edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage2_q <= '0;
      invert_q <= 1'b0;
    end
    else if (xfer_fire)
    begin
      stage2_q <= stage1_q;
      invert_q <= invert_in;
    end
  end

  assign stage1 = stage1_q;
  assign stage2 = stage2_q;
  assign invert_out = invert_q;

endmodule

// [logic/column_ahb_regs.sv]
// Purpose: AHB-Lite slave holding control and reporting loader state
// Assumes: Single word transfers; zero wait states
// Notes: Unmapped addresses read zero and ignore writes, always OKAY

`timescale 1ns/1ps

module column_ahb_regs
  import column_loader_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Block side
  output ctrl_type ctrl,
  input wire status_type status,
  input wire bank_type outputs
);

  logic [31:0] ctrl_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic access;
  logic [31:0] rd_value;

  // Valid address phase; hsize is not decoded since only words are used
  assign access = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Read decode
  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (haddr[7:0] == CTRL_OFFSET)
    begin
      rd_value = ctrl_q;
    end
    else if (haddr[7:0] == STATUS_OFFSET)
    begin
      rd_value[STAT_ACTIVE_BIT] = status.seq_active;
      rd_value[STAT_COUNT_LSB +: 3] = status.seq_count;
      rd_value[STAT_XFER_BIT] = status.xfer_pending;
    end
    else if (haddr[7:0] >= OUT_BASE_OFFSET && haddr[7:0] <= OUT_LAST_OFFSET && haddr[1:0] == 2'h0)
    begin
      rd_value[WORD_W-1:0] = outputs[3'((haddr[7:0] - OUT_BASE_OFFSET) >> 2)];
    end
  end

  // Read data registered so it stands through the data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (access && !hwrite)
    begin
      hrdata_q <= rd_value;
    end
  end

  // Write address captured for the data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= access && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Control register, only the three defined bits are kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (wr_pend_q && wr_addr_q == CTRL_OFFSET)
    begin
      ctrl_q <= hwdata & 32'h0000_0007;
    end
  end

  assign ctrl.direction = ctrl_q[CTRL_DIR_BIT];
  assign ctrl.edge_parity = ctrl_q[CTRL_PARITY_BIT];
  assign ctrl.polarity_invert = ctrl_q[CTRL_INVERT_BIT];
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

// [logic/column_load_sequencer.sv]
// Purpose: Steers panel pixel words into six column channel latches
// Assumes: Panel pins, panel clock included, are synchronous to clk
// Notes: Panel clock edges are found by sampling; controls come from CTRL
//
// Behaviour
// - Each accepted word loads exactly one channel
// - Second stage of all channels updates together
// - Start sampled high begins sequenced loading
// - Transfer copies first stage on falling edge
// - Direction low ascends, high descends
// - Six words after start fill channels 0..5
// - Parity high loads rising, low loads falling; addressed loads always on falling
// - Invert flag selects output slope
// - Addresses 0..5 load directly, 7 sequences
// - Transfer sampled rising, acts next falling

`timescale 1ns/1ps

module column_load_sequencer
  import column_loader_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel timing controller
  input wire panel_in_type panel_in,
  // Column data to the converters
  output bank_type column_outputs,
  output logic polarity_invert
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Channel of the n-th sequenced word for a given direction
  function automatic logic [2:0] seq_channel(input logic [2:0] count, input logic dir);
    seq_channel = dir ? 3'(LAST_CHANNEL - count) : count;
  endfunction

  // One-hot enable from a channel number, zero when out of range
  function automatic logic [CHANNELS-1:0] channel_onehot(input logic [2:0] ch);
    channel_onehot = (ch <= LAST_CHANNEL) ? 6'(6'h01 << ch) : 6'h00;
  endfunction

  ctrl_type ctrl;
  status_type status;
  bank_type stage1;
  bank_type stage2;
  logic pclk_q;
  logic rise;
  logic fall;
  logic load_edge;
  logic seq_mode;
  logic start_evt;
  logic [2:0] count_q;
  logic [2:0] addr_q;
  logic cs_q;
  logic xfer_pending_q;
  logic xfer_fire;
  logic seq_load;
  logic addr_load;
  logic [CHANNELS-1:0] load_en;

  // ----------------------------------------------------------------
  // Panel clock edges
  // ----------------------------------------------------------------

  // Previous panel clock level, so both edges can act on the system clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pclk_q <= 1'b0;
    end
    else
    begin
      pclk_q <= panel_in.panel_clock;
    end
  end

  assign rise = panel_in.panel_clock && !pclk_q;
  assign fall = !panel_in.panel_clock && pclk_q;
  assign load_edge = ctrl.edge_parity ? rise : fall;

  // ----------------------------------------------------------------
  // Internal sequencer
  // ----------------------------------------------------------------

  // all-ones address hands loading to the sequencer
  assign seq_mode = panel_in.channel_address == SEQ_ADDRESS;
  // start is only a start when sampled on a rising edge
  assign start_evt = rise && panel_in.sequence_start_or_select && seq_mode;

  // Count of words loaded; SEQ_DONE means idle. A new start always restarts,
  // so a controller that aborts mid-line simply begins again.
  // six counts then idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= SEQ_DONE;
    end
    else if (start_evt)
    begin
      count_q <= 3'h0;
    end
    else if (seq_load)
    begin
      count_q <= 3'(count_q + 3'h1);
    end
  end

  // no loads once six words are in
  assign seq_load = seq_mode && load_edge && !start_evt && count_q != SEQ_DONE;

  // ----------------------------------------------------------------
  // Addressed loading
  // ----------------------------------------------------------------

  // Address and chip select are taken on the rising edge and used at the fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= SEQ_ADDRESS;
      cs_q <= 1'b0;
    end
    else if (rise)
    begin
      addr_q <= panel_in.channel_address;
      cs_q <= panel_in.sequence_start_or_select;
    end
  end

  // direct load while selected and address in range
  assign addr_load = fall && cs_q && addr_q <= LAST_CHANNEL && !seq_mode;

  // one enable at most per accepted word
  // direction decides the channel for each count
  // direction is read live, so it must not move mid-sequence
  // same mapping on either load edge
  always_comb
  begin
    load_en = '0;
    if (seq_load)
    begin
      load_en = channel_onehot(seq_channel(count_q, ctrl.direction));
    end
    else if (addr_load)
    begin
      load_en = channel_onehot(addr_q);
    end
  end

  // ----------------------------------------------------------------
  // Transfer
  // ----------------------------------------------------------------

  // A strobe seen on several rises still fires only once per fall
  // strobe taken on rising edge, consumed on the next fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xfer_pending_q <= 1'b0;
    end
    else if (rise)
    begin
      xfer_pending_q <= panel_in.transfer_strobe;
    end
    else if (fall)
    begin
      xfer_pending_q <= 1'b0;
    end
  end

  // copy happens on the falling edge after a valid strobe
  assign xfer_fire = fall && xfer_pending_q;

  // ----------------------------------------------------------------
  // Latches and registers
  // ----------------------------------------------------------------

  // both stages live in the bank
  column_latch_bank u_bank (
    .clk(clk),
    .rst_n(rst_n),
    .load_en(load_en),
    .load_word(panel_in.pixel_word),
    .xfer_fire(xfer_fire),
    .invert_in(ctrl.polarity_invert),
    .stage1(stage1),
    .stage2(stage2),
    .invert_out(polarity_invert)
  );

  assign status.seq_active = count_q != SEQ_DONE;
  assign status.seq_count = count_q;
  assign status.xfer_pending = xfer_pending_q;

  column_ahb_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ctrl(ctrl),
    .status(status),
    .outputs(stage2)
  );

  assign column_outputs = stage2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Latch contents are watched, not only enables, so a broken decode shows
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_one_channel_load: assert property ($onehot0(load_en))
    else $error("more than one channel loaded");

  chk_bank_moves_together: assert property (xfer_fire |=> stage2 == $past(stage1))
    else $error("second stage did not take all first-stage words");

  chk_start_begins: assert property (start_evt |=> count_q == 3'h0)
    else $error("start did not reset the sequence");

  chk_xfer_on_fall: assert property (xfer_fire |-> fall && $past(xfer_pending_q))
    else $error("transfer outside a falling edge");

  chk_order_up: assert property (seq_load && !ctrl.direction |-> load_en == channel_onehot(count_q))
    else $error("ascending order broken");

  chk_order_down: assert property (seq_load && ctrl.direction |-> load_en[3'(LAST_CHANNEL - count_q)])
    else $error("descending order broken");

  chk_six_words: assert property (seq_load && count_q == LAST_CHANNEL |=> count_q == SEQ_DONE)
    else $error("sequence did not end after sixth word");

  chk_parity_edge: assert property (seq_load |-> (ctrl.edge_parity ? rise : fall))
    else $error("sequenced load on the wrong edge");

  chk_invert_follows: assert property (xfer_fire |=> polarity_invert == $past(ctrl.polarity_invert))
    else $error("slope flag not latched with transfer");

  chk_addr_direct: assert property (addr_load |-> load_en == channel_onehot(addr_q))
    else $error("addressed load to wrong channel");

  chk_strobe_sampled: assert property (rise && panel_in.transfer_strobe |=> xfer_pending_q)
    else $error("transfer strobe not captured");

  chk_idle_ignores: assert property (count_q == SEQ_DONE && seq_mode |=> stage1 == $past(stage1))
    else $error("load after sequence end");

  chk_count_range: assert property (count_q <= SEQ_DONE)
    else $error("sequence counter out of range");

  chk_start_no_load: assert property (start_evt |-> load_en == '0)
    else $error("word loaded on the start edge");

  chk_deselect_no_load: assert property (fall && !cs_q && !seq_mode |=> stage1 == $past(stage1))
    else $error("load while deselected");

  chk_stage2_holds: assert property (!xfer_fire |=> stage2 == $past(stage2))
    else $error("second stage moved without transfer");

  chk_strobe_consumed: assert property (fall |=> !xfer_pending_q)
    else $error("transfer strobe outlived its falling edge");

  cov_full_sequence: cover property (seq_load && count_q == LAST_CHANNEL);
  cov_transfer: cover property (xfer_fire);
  cov_addressed: cover property (addr_load);
  cov_reverse: cover property (seq_load && ctrl.direction && !ctrl.edge_parity);
  cov_forward_falling: cover property (seq_load && !ctrl.direction && !ctrl.edge_parity);

endmodule

// [bench/panel_ctrl_model.sv]
// Purpose: Panel timing controller model driving pixel words and strobes
// Assumes: Panel clock is built from clk, half period counted in clk cycles
// Notes: Panel clock stands still between calls; released lines show inverse data

`timescale 1ns/1ps

module panel_ctrl_model
  import column_loader_pkg::*;
(
  // Clock
  input wire logic clk,
  // Panel pins
  output panel_in_type panel_in
);
  // Half period in clk cycles; the bench raises it for slow answers
  int half = 2;

  // Quiet lines at time zero
  initial
  begin
    panel_in = '0;
  end

  // ----------------------------------------
  // One panel clock period
  // ----------------------------------------
  // word and strobes held over the rise
  task automatic pulse(input logic s, input logic x, input logic [2:0] a, input word_type w);
    panel_in <= '{1'b1, s, x, a, w};
    repeat (half) @(posedge clk);
    panel_in.panel_clock <= 1'b0;
    repeat (half) @(posedge clk);
    // Inverse data after release so a stale sample shows up
    panel_in <= '{1'b0, 1'b0, 1'b0, ~a, ~w};
    @(posedge clk);
  endtask
endmodule

// [bench/test_decimating_dac_load_sequencer.sv]
// Purpose: Self-checking bench for the column load sequencer
// Assumes: Zero wait state slave, hready tied to hreadyout
// Notes: Expected banks are built from the loading order, never read back first

`timescale 1ns/1ps

module test_decimating_dac_load_sequencer
  import column_loader_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic polarity_invert;
  bank_type column_outputs;
  panel_in_type panel_in;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  bank_type nxt = '0;
  bank_type cur = '0;
  logic pol = 1'b0;
  logic [31:0] rd;

  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #4 clk = ~clk;

  column_load_sequencer dut_u (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .panel_in(panel_in), .column_outputs(column_outputs), .polarity_invert(polarity_invert)
  );

  panel_ctrl_model model_u (
    .clk(clk),
    .panel_in(panel_in)
  );

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single AHB transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // Pins and registers of every channel against the expected bank
  task automatic check_bank();
    for (int i = 0; i < 6; i++)
    begin
      check("column output", 32'(column_outputs[i]), 32'(cur[i]));
      ahb(1'b0, 32'(OUT_BASE_OFFSET) + 32'(4 * i), 32'h0);
      check("column register", rd, 32'(cur[i]));
    end
    check("polarity", 32'(polarity_invert), 32'(pol));
  endtask

  // Sequenced load of six words, stray word, then transfer
  task automatic run_seq(input logic [2:0] ctrlv, input word_type base);
    ahb(1'b1, 32'(CTRL_OFFSET), {29'h0, ctrlv});
    if (ctrlv[CTRL_PARITY_BIT])
    begin
      model_u.pulse(1'b1, 1'b0, SEQ_ADDRESS, ~base);
      ahb(1'b0, 32'(STATUS_OFFSET), 32'h0);
      check("sequence active", {31'h0, rd[STAT_ACTIVE_BIT]}, 32'h1);
    end
    for (int k = 0; k < 6; k++)
    begin
      model_u.pulse(k == 0 && !ctrlv[CTRL_PARITY_BIT], 1'b0, SEQ_ADDRESS, base + word_type'(k));
      nxt[ctrlv[CTRL_DIR_BIT] ? 5 - k : k] = base + word_type'(k);
    end
    model_u.pulse(1'b0, 1'b0, SEQ_ADDRESS, ~base);
    ahb(1'b0, 32'(STATUS_OFFSET), 32'h0);
    check("status idle", rd, 32'h0000_000C);
    check_bank();
    model_u.pulse(1'b0, 1'b1, SEQ_ADDRESS, base);
    cur = nxt;
    pol = ctrlv[CTRL_INVERT_BIT];
    check_bank();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, 32'(CTRL_OFFSET), 32'h0);
    check("control reset", rd, CTRL_RESET);
    check_bank();
    // Rising-edge loads, both directions
    run_seq(3'h2, 10'h010);
    run_seq(3'h3, 10'h120);
    // Falling-edge loads, slow partner, inverted slope
    model_u.half = 3;
    run_seq(3'h0, 10'h230);
    run_seq(3'h5, 10'h3C0);
    model_u.half = 2;
    // Addressed loads; address 6 and a low select load nothing
    ahb(1'b1, 32'(CTRL_OFFSET), 32'h2);
    for (int a = 0; a < 7; a++)
    begin
      model_u.pulse(1'b1, 1'b0, 3'(a), word_type'(10'h3F0 - a));
      if (a < 6)
        nxt[a] = word_type'(10'h3F0 - a);
    end
    model_u.pulse(1'b0, 1'b0, 3'h2, 10'h0AA);
    model_u.pulse(1'b0, 1'b1, SEQ_ADDRESS, 10'h155);
    cur = nxt;
    pol = 1'b0;
    check_bank();
    // Unmapped place reads zero and keeps control intact
    ahb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0008, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("response okay", 32'(hresp), 32'h0);
    ahb(1'b0, 32'(CTRL_OFFSET), 32'h0);
    check("control kept", rd, 32'h2);
    // Reset in mid-run clears the second stage
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cur = '0;
    check_bank();
    complete_run();
  end
endmodule
